// ===== include/rcb_defines.svh
// Register map, field positions, reset values and timing constants of the regulator register bank
`ifndef RCB_DEFINES_SVH
`define RCB_DEFINES_SVH

`define RCB_BUS_ADDR          7'h18
`define RCB_REG_ID            8'h02
`define RCB_REG_FLAGS         8'h03
`define RCB_REG_LEVEL         8'h11
`define RCB_REG_CFG           8'h12
`define RCB_REG_OPT           8'h13

// Identity codes: values arbitrary
`define RCB_FAMILY_CODE       2'h1
`define RCB_REVISION_CODE     3'h5
`define RCB_VARIANT_CODE      3'h2

`define RCB_LEVEL_RST         8'h84
`define RCB_CFG_RST           8'h81
`define RCB_OPT_RST           8'h00
`define RCB_LEVEL_MIN         8'h48
`define RCB_LEVEL_MAX         8'hd7

`define RCB_CFG_SOFT_EN       7
`define RCB_CFG_DISCH         6
`define RCB_CFG_RATE_HI       5
`define RCB_CFG_RATE_LO       4
`define RCB_CFG_MODE_HI       3
`define RCB_CFG_MODE_LO       2
`define RCB_CFG_TYPE          0
`define RCB_OPT_OC_HI         7
`define RCB_OPT_OC_LO         6
`define RCB_OPT_OVR           5

`define RCB_FLAG_OC           0
`define RCB_FLAG_OT           1
`define RCB_FLAG_OVER         2
`define RCB_FLAG_UNDER        3

// One level step is 25 mV; time per step in ns for each rate code
`define RCB_STEP_MV_X1000     25000
`define RCB_CLK_NS            8
`define RCB_STEP_NS_R0        8000
`define RCB_STEP_NS_R1        4000
`define RCB_STEP_NS_R2        32000
`define RCB_STEP_NS_R3        16000
`define RCB_STEP_CYC(ns)      ((ns) / `RCB_CLK_NS)
`define RCB_HICCUP_MS         100
`define RCB_HICCUP_CYC        (`RCB_HICCUP_MS * 125000)

`endif

// ===== include/rcb_pkg.sv
// Types shared by the regulator register bank
package rcb_pkg;
	typedef enum logic [1:0] {
		RCB_MODE_AUTO   = 2'h0,
		RCB_MODE_RSVD   = 2'h1,
		RCB_MODE_PWM    = 2'h2,
		RCB_MODE_BYPASS = 2'h3
	} rcb_mode_t;

	typedef enum logic [1:0] {
		RCB_OC_HICCUP   = 2'h0,
		RCB_OC_SHUTDOWN = 2'h1,
		RCB_OC_LIMIT    = 2'h2,
		RCB_OC_RSVD     = 2'h3
	} rcb_oc_t;

	// Settings handed to the power stage
	typedef struct packed {
		logic      conv_en;
		logic      discharge_on;
		rcb_mode_t forced_mode_select;
		logic      type2_amp;
		rcb_oc_t   overcurrent_action_select;
		logic      hiccup_wait;
		logic [7:0] target_code;
	} rcb_ctrl_t;

	// Fault events from the power stage
	typedef struct packed {
		logic under_range;
		logic over_range;
		logic over_temp;
		logic over_current;
	} rcb_fault_t;
endpackage

// ===== design/rcb_i2c_target.sv
// I2C target engine on the bus clock: address match, register pointer, byte transfers
`include "rcb_defines.svh"
module rcb_i2c_target (
	// Link clock and reset
	input  wire logic       scl_i,
	input  wire logic       rst_n_i,
	// Data pin
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Register access on link clock
	output logic [7:0]      ptr_o,
	output logic [7:0]      wdata_o,
	output logic            wr_tgl_o,
	output logic            rd_tgl_o,
	input  wire logic [7:0] rdata_i
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_ACK  = 3'h2,
		ST_PTR  = 3'h3,
		ST_WR   = 3'h4,
		ST_RD   = 3'h5,
		ST_RACK = 3'h6
	} st_t;

	st_t        state_r;
	logic [2:0] bit_r;
	logic [7:0] sh_r;
	logic       rw_r;
	logic       ptr_done_r;
	logic       start_r;
	logic       stop_r;
	logic       start_seen;

	// Start and stop detection on data edges while clock is high
	always_ff @(negedge sda_i or negedge rst_n_i) begin
		if (!rst_n_i)
			start_r <= 1'b0;
		else if (scl_i)
			start_r <= ~start_r;
	end
	always_ff @(posedge sda_i or negedge rst_n_i) begin
		if (!rst_n_i)
			stop_r <= 1'b0;
		else if (scl_i)
			stop_r <= ~stop_r;
	end

	logic start_seen_r;
	logic stop_seen_r;
	always_ff @(posedge scl_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_seen_r <= 1'b0;
			stop_seen_r  <= 1'b0;
		end else begin
			start_seen_r <= start_r;
			stop_seen_r  <= stop_r;
		end
	end
	assign start_seen = start_r != start_seen_r;

	// Byte framing and protocol state
	always_ff @(posedge scl_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r    <= ST_IDLE;
			bit_r      <= 3'h7;
			sh_r       <= 8'h00;
			rw_r       <= 1'b0;
			ptr_done_r <= 1'b0;
			ptr_o      <= 8'h00;
			wdata_o    <= 8'h00;
			wr_tgl_o   <= 1'b0;
			rd_tgl_o   <= 1'b0;
		end else if (start_seen) begin
			state_r    <= ST_ADDR;
			bit_r      <= 3'h6;
			sh_r       <= {7'h00, sda_i};
			ptr_done_r <= 1'b0;
		end else if (stop_r != stop_seen_r) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: state_r <= ST_IDLE;
				ST_ADDR: begin
					sh_r  <= {sh_r[6:0], sda_i};
					bit_r <= bit_r - 3'h1;
					if (bit_r == 3'h0) begin
						rw_r <= sda_i;
						state_r <= (sh_r[6:0] == `RCB_BUS_ADDR) ? ST_ACK : ST_IDLE;
					end
				end
				ST_ACK, ST_RACK: begin
					bit_r <= 3'h7;
					if (state_r == ST_RACK && sda_i)
						state_r <= ST_IDLE;
					else if (rw_r) begin
						state_r  <= ST_RD;
						rd_tgl_o <= ~rd_tgl_o;
						sh_r     <= rdata_i; // Byte frozen before the read clears flags
					end else
						state_r <= ptr_done_r ? ST_WR : ST_PTR;
				end
				ST_PTR, ST_WR: begin
					sh_r  <= {sh_r[6:0], sda_i};
					bit_r <= bit_r - 3'h1;
					if (bit_r == 3'h0) begin
						state_r <= ST_ACK;
						if (state_r == ST_PTR) begin
							ptr_o      <= {sh_r[6:0], sda_i};
							ptr_done_r <= 1'b1;
						end else begin
							wdata_o  <= {sh_r[6:0], sda_i};
							wr_tgl_o <= ~wr_tgl_o;
						end
					end
				end
				ST_RD: begin
					bit_r <= bit_r - 3'h1;
					if (bit_r == 3'h0)
						state_r <= ST_RACK;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Drive ack low or read data on the falling edge
	always_ff @(negedge scl_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_o    <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			sda_o    <= 1'b0;
			sda_oe_o <= (state_r == ST_ACK) || (state_r == ST_RD && !sh_r[bit_r]);
		end
	end
endmodule

// ===== design/rcb_reg_bank.sv
// Regulator control register bank: I2C registers, ramp, fault flags and enable logic
`include "rcb_defines.svh"
module rcb_reg_bank (
	// System clock and reset
	input  wire logic               sys_clk_i,
	input  wire logic               rst_n_i,
	// I2C link
	input  wire logic               scl_i,
	input  wire logic               sda_i,
	output logic                    sda_o,
	output logic                    sda_oe_o,
	// Enable pin and fault events
	input  wire logic               en_pin_i,
	input  wire rcb_pkg::rcb_fault_t fault_i,
	// Power stage controls
	output rcb_pkg::rcb_ctrl_t      ctrl_o,
	output logic [7:0]              ramp_code_o
);
	logic [7:0] ptr_l;
	logic [7:0] wdata_l;
	logic       wr_tgl_l;
	logic       rd_tgl_l;
	logic [7:0] rdata_l;
	logic       link_rst_n;
	logic       en_s1_r;
	logic       en_s2_r;

	// Pin enable synchroniser; link logic held in reset while pin low
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
		end else begin
			en_s1_r <= en_pin_i;
			en_s2_r <= en_s1_r;
		end
	end
	// Low pin disables the serial interface
	assign link_rst_n = rst_n_i & en_pin_i;

	rcb_i2c_target u_tgt (
		.scl_i    (scl_i),
		.rst_n_i  (link_rst_n),
		.sda_i    (sda_i),
		.sda_o    (sda_o),
		.sda_oe_o (sda_oe_o),
		.ptr_o    (ptr_l),
		.wdata_o  (wdata_l),
		.wr_tgl_o (wr_tgl_l),
		.rd_tgl_o (rd_tgl_l),
		.rdata_i  (rdata_l)
	);

	// Toggle crossing of write and read events into system domain
	logic [2:0] wr_sync_r;
	logic [2:0] rd_sync_r;
	logic       wr_evt;
	logic       rd_evt;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_sync_r <= 3'h0;
			rd_sync_r <= 3'h0;
		end else begin
			wr_sync_r <= {wr_sync_r[1:0], wr_tgl_l};
			rd_sync_r <= {rd_sync_r[1:0], rd_tgl_l};
		end
	end
	assign wr_evt = wr_sync_r[2] != wr_sync_r[1];
	assign rd_evt = rd_sync_r[2] != rd_sync_r[1];

	logic [7:0] level_r;
	logic [7:0] cfg_r;
	logic [7:0] opt_r;
	logic [3:0] flags_r;
	logic [7:0] id_l;

	// Identity fields fixed in silicon; codes arbitrary
	assign id_l = {`RCB_FAMILY_CODE, `RCB_REVISION_CODE, `RCB_VARIANT_CODE};

	// Whole-byte register writes; identity and flags are not written
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_r <= `RCB_LEVEL_RST;
			cfg_r   <= `RCB_CFG_RST;
			opt_r   <= `RCB_OPT_RST;
		end else if (wr_evt) begin
			// Writes to 0x02 and 0x03 fall through unchanged
			unique case (ptr_l)
				`RCB_REG_LEVEL: level_r <= wdata_l;
				`RCB_REG_CFG:   cfg_r   <= wdata_l;
				`RCB_REG_OPT:   opt_r   <= wdata_l;
				default:        level_r <= level_r;
			endcase
		end
	end

	// Read mux; only five addresses decode, others read zero
	always_comb begin
		unique case (ptr_l)
			`RCB_REG_ID:    rdata_l = id_l;
			`RCB_REG_FLAGS: rdata_l = {4'h0, flags_r};
			`RCB_REG_LEVEL: rdata_l = level_r;
			`RCB_REG_CFG:   rdata_l = cfg_r;
			`RCB_REG_OPT:   rdata_l = opt_r;
			default:        rdata_l = 8'h00;
		endcase
	end

	// Fault event synchroniser and edge detect
	logic [3:0] flt_s1_r;
	logic [3:0] flt_s2_r;
	logic [3:0] flt_s3_r;
	logic [3:0] flt_rise;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flt_s1_r <= 4'h0;
			flt_s2_r <= 4'h0;
			flt_s3_r <= 4'h0;
		end else begin
			flt_s1_r <= fault_i;
			flt_s2_r <= flt_s1_r;
			flt_s3_r <= flt_s2_r;
		end
	end
	assign flt_rise = flt_s2_r & ~flt_s3_r;

	// Sticky flags, cleared by read; a new event wins
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			flags_r <= 4'h0;
		else if (rd_evt && ptr_l == `RCB_REG_FLAGS)
			flags_r <= flt_rise;
		else
			flags_r <= flags_r | flt_rise;
	end

	// Clamp of level code to 1.8 V .. 5.375 V
	function automatic logic [7:0] clamp_level(input logic [7:0] c);
		if (c < `RCB_LEVEL_MIN)
			clamp_level = `RCB_LEVEL_MIN;
		else if (c > `RCB_LEVEL_MAX)
			clamp_level = `RCB_LEVEL_MAX;
		else
			clamp_level = c;
	endfunction

	// Cycles per 25 mV step for each rate code
	function automatic logic [15:0] step_cycles(input logic [1:0] r);
		unique case (r)
			2'h0: step_cycles = 16'(`RCB_STEP_CYC(`RCB_STEP_NS_R0));
			2'h1: step_cycles = 16'(`RCB_STEP_CYC(`RCB_STEP_NS_R1));
			2'h2: step_cycles = 16'(`RCB_STEP_CYC(`RCB_STEP_NS_R2));
			2'h3: step_cycles = 16'(`RCB_STEP_CYC(`RCB_STEP_NS_R3));
		endcase
	endfunction

	logic [7:0]  target_l;
	logic [7:0]  ramp_r;
	logic [15:0] step_cnt_r;
	assign target_l = clamp_level(level_r);

	// Ramp up one step per interval, drop at once when lower
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ramp_r     <= `RCB_LEVEL_RST;
			step_cnt_r <= 16'h0000;
		end else if (ramp_r >= target_l) begin
			ramp_r     <= target_l;
			step_cnt_r <= 16'h0000;
		end else if (step_cnt_r + 16'h0001 >= step_cycles(cfg_r[`RCB_CFG_RATE_HI:`RCB_CFG_RATE_LO])) begin
			ramp_r     <= ramp_r + 8'h01;
			step_cnt_r <= 16'h0000;
		end else begin
			step_cnt_r <= step_cnt_r + 16'h0001;
		end
	end

	// Enable override latch: push-button keeps the converter on
	logic ovr_hold_r;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ovr_hold_r <= 1'b0;
		// Override latches pin-high while bit set
		else if (!opt_r[`RCB_OPT_OVR])
			ovr_hold_r <= 1'b0;
		else if (en_s2_r)
			ovr_hold_r <= 1'b1;
	end

	// Hiccup wait timer after an overcurrent event
	logic [23:0] hic_cnt_r;
	logic        shut_r;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hic_cnt_r <= 24'h000000;
			shut_r    <= 1'b0;
		end else begin
			// Code 0 waits 100 ms, code 1 latches off
			if (flt_rise[`RCB_FLAG_OC] && opt_r[`RCB_OPT_OC_HI:`RCB_OPT_OC_LO] == rcb_pkg::RCB_OC_HICCUP)
				hic_cnt_r <= 24'(`RCB_HICCUP_CYC);
			else if (hic_cnt_r != 24'h000000)
				hic_cnt_r <= hic_cnt_r - 24'h000001;
			if (flt_rise[`RCB_FLAG_OC] && opt_r[`RCB_OPT_OC_HI:`RCB_OPT_OC_LO] == rcb_pkg::RCB_OC_SHUTDOWN)
				shut_r <= 1'b1;
			else if (!en_s2_r || !cfg_r[`RCB_CFG_SOFT_EN])
				shut_r <= 1'b0;
		end
	end

	logic pin_en;
	assign pin_en = en_s2_r | ovr_hold_r;

	// Control outputs from flip-flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_o      <= '0;
			ramp_code_o <= 8'h00;
		end else begin
			ctrl_o.conv_en <= pin_en & cfg_r[`RCB_CFG_SOFT_EN] & ~shut_r & (hic_cnt_r == 24'h000000);
			// Discharge only when soft-disabled and selected
			ctrl_o.discharge_on <= cfg_r[`RCB_CFG_DISCH] & ~cfg_r[`RCB_CFG_SOFT_EN];
			ctrl_o.forced_mode_select <= rcb_pkg::rcb_mode_t'(cfg_r[`RCB_CFG_MODE_HI:`RCB_CFG_MODE_LO]);
			ctrl_o.type2_amp <= cfg_r[`RCB_CFG_TYPE];
			ctrl_o.overcurrent_action_select <= rcb_pkg::rcb_oc_t'(opt_r[`RCB_OPT_OC_HI:`RCB_OPT_OC_LO]);
			ctrl_o.hiccup_wait <= hic_cnt_r != 24'h000000;
			ctrl_o.target_code <= target_l;
			ramp_code_o        <= ramp_r;
		end
	end

	// Checks
	a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(rd_evt && ptr_l == `RCB_REG_FLAGS && flt_rise == 4'h0) |=> flags_r == 4'h0)
		else $error("flags not cleared by read");
	a_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		flt_rise[`RCB_FLAG_OC] |=> flags_r[`RCB_FLAG_OC]) else $error("fault flag not set");
	a_ro_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr_evt && ptr_l == `RCB_REG_ID) |=> $stable(level_r) && $stable(cfg_r) && $stable(opt_r))
		else $error("read-only write changed state");
	a_ramp_up: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ramp_r != $past(ramp_r) |-> ramp_r == $past(ramp_r) + 8'h01 || ramp_r == $past(target_l))
		else $error("ramp jumped");
	a_level_clamp: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		target_l >= `RCB_LEVEL_MIN && target_l <= `RCB_LEVEL_MAX) else $error("level out of range");
	a_soft_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!cfg_r[`RCB_CFG_SOFT_EN] |=> !ctrl_o.conv_en) else $error("converter on while soft disabled");
	a_discharge: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		ctrl_o.discharge_on |-> $past(cfg_r[`RCB_CFG_DISCH])) else $error("discharge without select");
	a_pin_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!en_s2_r && !ovr_hold_r) |=> !ctrl_o.conv_en) else $error("converter on with pin low");
	a_mode_copy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		##1 ctrl_o.forced_mode_select == $past(cfg_r[`RCB_CFG_MODE_HI:`RCB_CFG_MODE_LO])) else $error("mode mismatch");
	c_write: cover property (@(posedge sys_clk_i) wr_evt && ptr_l == `RCB_REG_LEVEL);
	c_flag_read: cover property (@(posedge sys_clk_i) rd_evt && ptr_l == `RCB_REG_FLAGS && flags_r != 4'h0);
	c_ramp: cover property (@(posedge sys_clk_i) ramp_r < target_l ##1 ramp_r == target_l);
endmodule

// ===== test/rcb_i2c_ctl_model.sv
// I2C controller model that reaches the regulator register bank
module rcb_i2c_ctl_model (
	// Link pins
	output logic       scl_o,
	output logic       sda_pull_o,
	input  wire logic  sda_i,
	// Read results
	output logic       rd_valid_o,
	output logic [7:0] rd_byte_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus: clock stands high, data released
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_byte_o = 8'h00;
	end

	// One bit: data moves while clock low, sampled mid-high
	task automatic bit_io(input logic b, output logic s);
		#1 sda_pull_o = ~b;
		#2 scl_o = 1'b1;
		#1.5 s = sda_i;
		#1.5 scl_o = 1'b0;
	endtask

	// Start and stop conditions
	task automatic start_c();
		#3 sda_pull_o = 1'b1;
		#3 scl_o = 1'b0;
	endtask
	task automatic stop_c();
		#1 sda_pull_o = 1'b1;
		#2 scl_o = 1'b1;
		#3 sda_pull_o = 1'b0;
		#40;
	endtask

	// byte out MSB first, then released acknowledge slot
	task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
			r[i] = s;
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data,
		input logic with_data, output logic ok);
		logic [7:0] r;
		logic       a0;
		logic       a1;
		logic       a2;
		start_c();
		xfer({dev, 1'b0}, r, a0);
		xfer(ptr, r, a1);
		a2 = 1'b1;
		if (with_data) begin
			xfer(data, r, a2);
		end
		stop_c();
		ok = a0 & a1 & a2;
	endtask

	// pointer set, then one byte read with no acknowledge
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic ok);
		logic [7:0] r;
		logic       a0;
		logic       a1;
		logic       d;
		write_reg(dev, ptr, 8'h00, 1'b0, a0);
		start_c();
		xfer({dev, 1'b1}, r, a1);
		if (a0 & a1) begin
			xfer(8'hff, r, d);
			rd_byte_o = r;
			rd_valid_o = 1'b1;
		end
		stop_c();
		rd_valid_o = 1'b0;
		ok = a0 & a1;
	endtask
endmodule

// ===== test/rcb_reg_bank_test.sv
// Self-checking bench for the regulator register bank
`include "rcb_defines.svh"
module rcb_reg_bank_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic                sys_clk;
	logic                rst_n;
	logic                en_pin;
	rcb_pkg::rcb_fault_t fault;
	rcb_pkg::rcb_ctrl_t  ctrl;
	logic [7:0]          ramp;
	logic                scl;
	logic                sda_pull;
	logic                sda_line;
	logic                sda_o;
	logic                sda_oe;
	logic                rd_valid;
	logic [7:0]          rd_byte;
	logic [7:0]          exp_q[$];
	logic [7:0]          v;
	logic                ack;
	int                  errors;
	int                  comparisons;
	int                  seed;
	int                  step_cyc[4] = '{1000, 500, 4000, 2000};
	logic [7:0]          unm[4] = '{8'h00, 8'h04, 8'h10, 8'h14};
	rcb_pkg::rcb_mode_t  modes[3] = '{rcb_pkg::RCB_MODE_AUTO, rcb_pkg::RCB_MODE_PWM, rcb_pkg::RCB_MODE_BYPASS};
	localparam logic [7:0] ID = {`RCB_FAMILY_CODE, `RCB_REVISION_CODE, `RCB_VARIANT_CODE};

	// System clock, 8 ns
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;
	// Open-drain data line with pull-up
	assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));

	rcb_reg_bank u_rcb_reg_bank (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .en_pin_i(en_pin), .fault_i(fault), .ctrl_o(ctrl), .ramp_code_o(ramp));
	rcb_i2c_ctl_model u_rcb_i2c_ctl_model (.scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda_line),
		.rd_valid_o(rd_valid), .rd_byte_o(rd_byte));

	// Compare and count
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic ctrl_is(input logic [7:0] exp, input string what);
		check({1'b0, ctrl.conv_en, ctrl.discharge_on, ctrl.forced_mode_select, ctrl.type2_amp,
			ctrl.overcurrent_action_select}, exp, what);
	endtask

	// Register access over the link
	task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
		u_rcb_i2c_ctl_model.write_reg(`RCB_BUS_ADDR, ptr, data, 1'b1, ack);
		repeat (10) @(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
		exp_q.push_back(exp);
		u_rcb_i2c_ctl_model.read_reg(`RCB_BUS_ADDR, ptr, ack);
		check({7'h00, ack}, 8'h01, "read acknowledge");
	endtask

	// Pin and fault stimulus
	task automatic set_pin(input logic b);
		@(posedge sys_clk);
		en_pin <= b;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic pulse(input logic [3:0] f);
		@(posedge sys_clk);
		fault <= f;
		repeat (2) @(posedge sys_clk);
		fault <= '0;
		repeat (4) @(posedge sys_clk);
	endtask

	// Each read byte against the oldest expectation
	always @(posedge rd_valid) begin
		if (exp_q.size() == 0) begin
			errors++;
			$display("ERROR %0t unexpected read", $time);
		end else begin
			check(rd_byte, exp_q.pop_front(), "read data");
		end
	end

	task automatic tally_and_finish();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#600us;
		errors++;
		$display("ERROR %0t watchdog expired", $time);
		tally_and_finish();
	end

	// Main sequence
	initial begin
		errors = 0;
		comparisons = 0;
		seed = 90692;
		rst_n = 1'b0;
		en_pin = 1'b1;
		fault = '0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(`RCB_REG_ID, ID);
		rd(`RCB_REG_LEVEL, 8'h84);
		rd(`RCB_REG_CFG, 8'h81);
		rd(`RCB_REG_OPT, 8'h00);
		ctrl_is(8'h44, "reset controls");
		$display("test reset values done");
		v = 8'($random(seed));
		wr(`RCB_REG_ID, v);
		wr(`RCB_REG_FLAGS, v);
		rd(`RCB_REG_ID, ID);
		rd(`RCB_REG_FLAGS, 8'h00);
		foreach (unm[i]) begin
			wr(unm[i], v);
			rd(unm[i], 8'h00);
		end
		u_rcb_i2c_ctl_model.write_reg(`RCB_BUS_ADDR ^ 7'h01, `RCB_REG_LEVEL, 8'h50, 1'b1, ack);
		check({7'h00, ack}, 8'h00, "foreign address acknowledged");
		rd(`RCB_REG_LEVEL, 8'h84);
		$display("test refusals done");
		foreach (modes[m]) begin
			for (int t = 0; t < 2; t++) begin
				v = {2'b10, 2'($random(seed)), modes[m], 1'($random(seed)), t[0]};
				wr(`RCB_REG_CFG, v);
				rd(`RCB_REG_CFG, v);
				ctrl_is({3'b010, modes[m], t[0], 2'b00}, "mode and amplifier");
			end
		end
		wr(`RCB_REG_CFG, 8'h40);
		ctrl_is(8'h20, "soft off with discharge");
		wr(`RCB_REG_CFG, 8'h00);
		ctrl_is(8'h00, "soft off no discharge");
		wr(`RCB_REG_CFG, 8'hc1);
		ctrl_is(8'h44, "soft on");
		wr(`RCB_REG_CFG, 8'h81);
		set_pin(1'b0);
		ctrl_is(8'h04, "pin low");
		set_pin(1'b1);
		ctrl_is(8'h44, "pin high");
		$display("test configuration done");
		for (int o = 0; o < 3; o++) begin
			v = {o[1:0], 6'h00};
			wr(`RCB_REG_OPT, v);
			rd(`RCB_REG_OPT, v);
			ctrl_is({6'b010001, o[1:0]}, "overcurrent action");
		end
		wr(`RCB_REG_OPT, 8'h20);
		set_pin(1'b0);
		ctrl_is(8'h44, "override holds");
		set_pin(1'b1);
		wr(`RCB_REG_OPT, 8'h00);
		set_pin(1'b0);
		ctrl_is(8'h04, "override off");
		set_pin(1'b1);
		$display("test options done");
		for (int b = 0; b < 4; b++) begin
			pulse(4'(1 << b));
			rd(`RCB_REG_FLAGS, 8'(1 << b));
			rd(`RCB_REG_FLAGS, 8'h00);
		end
		v = 8'($random(seed)) & 8'h0f;
		pulse(v[3:0]);
		rd(`RCB_REG_FLAGS, v);
		ctrl_is(8'h04, "hiccup holds converter off");
		check({7'h00, ctrl.hiccup_wait}, 8'h01, "hiccup wait");
		$display("test fault flags done");
		for (int r = 0; r < 4; r++) begin
			wr(`RCB_REG_CFG, {2'b10, 2'(r), 4'h1});
			wr(`RCB_REG_LEVEL, 8'h60);
			check(ramp, 8'h60, "ramp down");
			wr(`RCB_REG_LEVEL, 8'h63);
			repeat (step_cyc[r] * 19 / 10) @(posedge sys_clk);
			check({7'h00, ramp < 8'h63}, 8'h01, "ramp too fast");
			repeat (step_cyc[r] * 12 / 10) @(posedge sys_clk);
			check(ramp, 8'h63, "ramp too slow");
		end
		wr(`RCB_REG_LEVEL, 8'h10);
		check(ramp, 8'h48, "low clamp");
		check(ctrl.target_code, 8'h48, "low clamp target");
		wr(`RCB_REG_LEVEL, 8'hff);
		check(ctrl.target_code, 8'hd7, "high clamp target");
		$display("test ramp done");
		tally_and_finish();
	end
endmodule
